// ---- rtl/status_sleep_ctrl.sv ----
// status indicator blink patterns and sleep/wake gating
// assumes synchronous inputs, one clock; the host drives the wake pin and the serial port
// Behaviour
// - no sim, pin, registering or failed: 600 ms high, 600 ms low, repeat
// - standby: 75 ms low then 3000 ms high, repeat
// - data link setup: 75 ms low then 75 ms high, repeat
// - registering pattern only while registration lasted under 15 s
// - no sleep after reset until a non-zero sleep delay is written
// - sleep after delay seconds; delay not retained over power-down
// - policy 2: never sleep while wake input is high; setting not retained over power-down
// - policy 1: never sleep while wake input is low
// - policy 0 default: wake input transition wakes, sleep again after idle
// - only primary serial port activity wakes; other ports ignored
`timescale 1ns/10ps
module status_sleep_ctrl #(
	parameter int unsigned IDLE_MS  = status_sleep_pkg::IDLE_WAKE_MS,
	// clocks per millisecond; a bench may shorten it to reach second-long timings
	parameter int unsigned TICK_CYC = status_sleep_pkg::TICK_CYCLES
) (
	// clock, reset, enable
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_ce,
	// module state
	input  wire logic [2:0] i_state,
	// configuration from the command handler
	input  wire logic       i_delay_wr,
	input  wire logic [7:0] i_delay_val,
	input  wire logic       i_policy_wr,
	input  wire logic [1:0] i_policy_val,
	// wake sources
	input  wire logic       i_wake_key,
	input  wire logic       i_primary_rx_act,
	input  wire logic       i_other_rx_act,
	// outputs
	output logic            o_status_indicator_out,
	output logic            o_asleep,
	output logic [1:0]      o_wake_policy
);
	ms_tick_if tk ();
	ms_tick_gen #(
		.CYCLES   (TICK_CYC)
	) u_tick (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_ce     (i_ce),
		.tick_if  (tk)
	);

	localparam int unsigned LIMIT_MS = status_sleep_pkg::REG_LIMIT_MS;

	logic [7:0]  delay_r;
	logic [1:0]  policy_r;
	logic        asleep_r;
	logic        wake_prev_r;
	logic [17:0] idle_ms_r;
	logic [13:0] reg_ms_r;
	logic [11:0] phase_ms_r;
	logic        level_r;
	logic        led_r;
	status_sleep_pkg::pattern_t pat_r;
	status_sleep_pkg::pattern_t pat;

	// registering counts as searching only while under the limit
	wire in_reg      = (i_state == status_sleep_pkg::ST_REGISTERING);
	wire reg_fresh   = in_reg && (reg_ms_r < 14'(LIMIT_MS));
	wire searching   = (i_state == status_sleep_pkg::ST_NO_SIM) ||
	                   (i_state == status_sleep_pkg::ST_PIN) || reg_fresh ||
	                   (i_state == status_sleep_pkg::ST_REG_FAIL);
	wire wake_edge   = (i_wake_key != wake_prev_r);
	// level policies block sleep outright; edge policy only wakes
	wire hold_awake  = ((policy_r == status_sleep_pkg::POLICY_HI_HOLD) && i_wake_key) ||
	                   ((policy_r == status_sleep_pkg::POLICY_LOW_HOLD) && !i_wake_key);
	// only the primary port counts; i_other_rx_act is deliberately ignored
	wire activity    = i_primary_rx_act ||
	                   ((policy_r == status_sleep_pkg::POLICY_EDGE) && wake_edge);
	wire [17:0] delay_ms = 18'(delay_r * status_sleep_pkg::MS_PER_S);
	wire [17:0] target_ms = asleep_r ? 18'(IDLE_MS) : delay_ms;
	wire sleep_ok    = (delay_r != 8'h00) && !hold_awake;
	wire go_sleep    = !asleep_r && sleep_ok && tk.tick && (idle_ms_r + 18'h00001 >= delay_ms);
	wire wake_now    = asleep_r && (activity || hold_awake);

	// pattern select; steady levels override blinking
	always_comb begin
		if (asleep_r)
			pat = status_sleep_pkg::PAT_HIGH;
		else if (i_state == status_sleep_pkg::ST_VOICE)
			pat = status_sleep_pkg::PAT_LOW;
		else if (i_state == status_sleep_pkg::ST_DATA_LINK)
			pat = status_sleep_pkg::PAT_LINK;
		else if (searching)
			pat = status_sleep_pkg::PAT_SEARCH;
		else
			pat = status_sleep_pkg::PAT_STANDBY;
	end

	// half-period length of the current level for the active pattern
	function automatic logic [11:0] half_len(input status_sleep_pkg::pattern_t p,
	                                         input logic lvl);
		case (p)
			status_sleep_pkg::PAT_SEARCH:  half_len = 12'(status_sleep_pkg::SEARCH_HALF_MS);
			status_sleep_pkg::PAT_STANDBY: half_len = lvl ? 12'(status_sleep_pkg::STANDBY_HIGH_MS)
			                                              : 12'(status_sleep_pkg::STANDBY_LOW_MS);
			status_sleep_pkg::PAT_LINK:    half_len = 12'(status_sleep_pkg::LINK_HALF_MS);
			default:                       half_len = 12'hfff;
		endcase
	endfunction

	wire       pat_change = (pat != pat_r);
	wire       phase_end  = tk.tick && (phase_ms_r + 12'h001 >= half_len(pat_r, level_r));
	// search starts high, standby and link start low
	wire       start_lvl  = (pat == status_sleep_pkg::PAT_SEARCH) ||
	                        (pat == status_sleep_pkg::PAT_HIGH);

	// configuration; cleared only by reset, which stands in for power-down
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			delay_r  <= status_sleep_pkg::SLEEP_DELAY_RST;
			policy_r <= status_sleep_pkg::POLICY_RST;
		end else if (i_ce) begin
			if (i_delay_wr)
				delay_r <= i_delay_val;
			if (i_policy_wr)
				policy_r <= i_policy_val;
		end
	end

	// sleep state and idle timer; activity restarts the idle count
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			asleep_r    <= 1'b0;
			wake_prev_r <= 1'b1; // pin idles high, so no false edge follows reset
			idle_ms_r   <= 18'h00000;
		end else if (i_ce) begin
			wake_prev_r <= i_wake_key;
			if (wake_now) begin
				asleep_r  <= 1'b0;
				idle_ms_r <= 18'h00000;
			end else if (go_sleep) begin
				asleep_r  <= 1'b1;
				idle_ms_r <= 18'h00000;
			end else if (activity || hold_awake || i_delay_wr) begin
				idle_ms_r <= 18'h00000;
			end else if (tk.tick && idle_ms_r < target_ms) begin
				idle_ms_r <= idle_ms_r + 18'h00001;
			end
		end
	end

	// registration duration counter, saturating at the limit
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			reg_ms_r <= 14'h0000;
		else if (i_ce) begin
			if (!in_reg)
				reg_ms_r <= 14'h0000;
			else if (tk.tick && reg_fresh)
				reg_ms_r <= reg_ms_r + 14'h0001;
		end
	end

	// blink sequencer; a pattern change restarts at the pattern's first level
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pat_r      <= status_sleep_pkg::PAT_SEARCH;
			level_r    <= 1'b1;
			phase_ms_r <= 12'h000;
			led_r      <= 1'b0;
		end else if (i_ce) begin
			if (pat_change) begin
				pat_r      <= pat;
				level_r    <= start_lvl;
				phase_ms_r <= 12'h000;
			end else if (phase_end && pat_r != status_sleep_pkg::PAT_HIGH &&
			             pat_r != status_sleep_pkg::PAT_LOW) begin
				level_r    <= !level_r;
				phase_ms_r <= 12'h000;
			end else if (tk.tick) begin
				phase_ms_r <= phase_ms_r + 12'h001;
			end
			led_r <= pat_change ? start_lvl : level_r;
		end
	end

	assign o_status_indicator_out = led_r;
	assign o_asleep               = asleep_r;
	assign o_wake_policy          = policy_r;

	a_no_sleep_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(delay_r == 8'h00) |-> ##1 !$rose(asleep_r)) else $error("sleep with zero delay");
	a_hi_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_ce && policy_r == status_sleep_pkg::POLICY_HI_HOLD && i_wake_key)
		|=> !asleep_r) else $error("slept with wake high");
	a_low_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_ce && policy_r == status_sleep_pkg::POLICY_LOW_HOLD && !i_wake_key)
		|=> !asleep_r) else $error("slept with wake low");
	a_primary_wake: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_ce && asleep_r && i_primary_rx_act) |=> !asleep_r)
		else $error("primary port did not wake");
	// traffic on the other ports alone must leave a sleeping device asleep
	a_other_no_wake: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_ce && asleep_r && i_other_rx_act && !i_primary_rx_act && !hold_awake &&
		 !wake_edge) |=> asleep_r)
		else $error("other port woke the device");
	a_edge_wake: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_ce && asleep_r && policy_r == status_sleep_pkg::POLICY_EDGE && wake_edge)
		|=> !asleep_r) else $error("wake edge ignored");
	a_sleep_led: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_ce && asleep_r) ##1 (i_ce && asleep_r) |=> o_status_indicator_out)
		else $error("indicator not high asleep");
	a_voice_led: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_ce && !asleep_r && i_state == status_sleep_pkg::ST_VOICE) [*2]
		|=> !o_status_indicator_out) else $error("indicator not low in call");
	a_reg_limit: assert property (@(posedge i_clk) disable iff (!i_resetn)
		reg_ms_r <= 14'(LIMIT_MS)) else $error("registration count overran");
	a_search_half: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(pat_r == status_sleep_pkg::PAT_SEARCH)
		|-> phase_ms_r < 12'(status_sleep_pkg::SEARCH_HALF_MS))
		else $error("search half period too long");
	a_link_half: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(pat_r == status_sleep_pkg::PAT_LINK)
		|-> phase_ms_r < 12'(status_sleep_pkg::LINK_HALF_MS))
		else $error("link half period too long");
	a_standby_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(pat_r == status_sleep_pkg::PAT_STANDBY && !level_r)
		|-> phase_ms_r < 12'(status_sleep_pkg::STANDBY_LOW_MS))
		else $error("standby low too long");
endmodule

// ---- rtl/status_sleep_pkg.sv ----
// constants shared by the status indicator and sleep/wake gating design
// assumes a 125 MHz core clock and a one millisecond timebase derived from it
package status_sleep_pkg;
	localparam int unsigned CLK_HZ          = 125_000_000;
	localparam int unsigned TICK_NS         = 1_000_000;
	localparam int unsigned TICK_CYCLES     = TICK_NS / (1_000_000_000 / CLK_HZ);
	localparam int unsigned SEARCH_HALF_MS  = 600;
	localparam int unsigned STANDBY_LOW_MS  = 75;
	localparam int unsigned STANDBY_HIGH_MS = 3000;
	localparam int unsigned LINK_HALF_MS    = 75;
	localparam int unsigned REG_LIMIT_MS    = 15000;
	localparam int unsigned MS_PER_S        = 1000;
	localparam int unsigned IDLE_WAKE_MS    = 2000;
	localparam logic [7:0]  SLEEP_DELAY_RST = 8'h00;
	localparam logic [1:0]  POLICY_EDGE     = 2'h0;
	localparam logic [1:0]  POLICY_LOW_HOLD = 2'h1;
	localparam logic [1:0]  POLICY_HI_HOLD  = 2'h2;
	localparam logic [1:0]  POLICY_RST      = 2'h0;
	localparam logic [2:0]  ST_NO_SIM       = 3'h0;
	localparam logic [2:0]  ST_PIN          = 3'h1;
	localparam logic [2:0]  ST_REGISTERING  = 3'h2;
	localparam logic [2:0]  ST_REG_FAIL     = 3'h3;
	localparam logic [2:0]  ST_STANDBY      = 3'h4;
	localparam logic [2:0]  ST_DATA_LINK    = 3'h5;
	localparam logic [2:0]  ST_VOICE        = 3'h6;
	typedef enum logic [2:0] {
		PAT_SEARCH,
		PAT_STANDBY,
		PAT_LINK,
		PAT_HIGH,
		PAT_LOW
	} pattern_t;
endpackage

// ---- rtl/ms_tick_if.sv ----
// carrier of the millisecond timebase between the tick generator and the top
// assumes a single clock domain
`timescale 1ns/10ps
interface ms_tick_if;
	logic tick;
	modport source (output tick);
	modport sink   (input  tick);
endinterface

// ---- rtl/ms_tick_gen.sv ----
// millisecond tick generator: one-cycle pulse every TICK_CYCLES clocks
// assumes i_clk at the package rate; frozen while i_ce is low
`timescale 1ns/10ps
module ms_tick_gen #(
	parameter int unsigned CYCLES = status_sleep_pkg::TICK_CYCLES
) (
	input  wire logic  i_clk,
	input  wire logic  i_resetn,
	input  wire logic  i_ce,
	ms_tick_if.source  tick_if
);
	logic [16:0] cnt_r;
	logic        tick_r;
	wire         wrap = (cnt_r == 17'(CYCLES - 1));

	// free running divider; the pulse is registered so the sink sees a clean edge
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_r  <= 17'h00000;
			tick_r <= 1'b0;
		end else if (i_ce) begin
			cnt_r  <= wrap ? 17'h00000 : cnt_r + 17'h00001;
			tick_r <= wrap;
		end
	end
	assign tick_if.tick = tick_r;
endmodule

// ---- sim/host_ap_model.sv ----
// host processor model driving the wake pin and the serial port activity lines
// assumes the bench calls its tasks from the i_clk domain
`timescale 1ns/10ps
module host_ap_model (
	// clock
	input  wire logic i_clk,
	// pins toward the device
	output logic      o_wake_key,
	output logic      o_primary_rx_act,
	output logic      o_other_rx_act
);
	// wake pin idles high as if pulled up while it floats
	initial begin
		o_wake_key       = 1'b1;
		o_primary_rx_act = 1'b0;
		o_other_rx_act   = 1'b0;
	end
	// repeated command bursts; an edge passes before each new strobe
	task automatic send_cmds(input bit primary, input int n);
		repeat (n) begin
			@(posedge i_clk);
			if (primary) o_primary_rx_act <= 1'b1;
			else o_other_rx_act <= 1'b1;
			@(posedge i_clk);
			o_primary_rx_act <= 1'b0;
			o_other_rx_act   <= 1'b0;
		end
	endtask
	// wake level chosen by the host for the policy in use
	task automatic set_wake(input logic lvl);
		@(posedge i_clk);
		o_wake_key <= lvl;
	endtask
endmodule

// ---- sim/status_indicator_sleep_wake_tb.sv ----
// self-checking bench for the status indicator and sleep/wake gating block
// assumes the top's tick parameter is shortened so that one ms lasts MS_CYC clocks
`timescale 1ns/10ps
module status_indicator_sleep_wake_tb;
	logic       clk;
	logic       resetn;
	logic       ce;
	logic [2:0] state;
	logic       delay_wr;
	logic [7:0] delay_val;
	logic       policy_wr;
	logic [1:0] policy_val;
	logic       wake_key;
	logic       prim_act;
	logic       other_act;
	logic       led;
	logic       asleep;
	logic [1:0] policy;
	int         bad_count;
	int         tests_run;
	// clocks per ms; short so that second-long timings fit the run
	localparam int unsigned MS_CYC = 2;
	// start level of each pattern, indexed by module state
	logic [7:0] start_lvl [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

	status_sleep_ctrl #(
		.TICK_CYC(MS_CYC)
	) status_sleep_ctrl_inst (
		.i_clk(clk), .i_resetn(resetn), .i_ce(ce), .i_state(state),
		.i_delay_wr(delay_wr), .i_delay_val(delay_val),
		.i_policy_wr(policy_wr), .i_policy_val(policy_val),
		.i_wake_key(wake_key), .i_primary_rx_act(prim_act), .i_other_rx_act(other_act),
		.o_status_indicator_out(led), .o_asleep(asleep), .o_wake_policy(policy)
	);
	host_ap_model host_ap_model_inst (
		.i_clk(clk), .o_wake_key(wake_key),
		.o_primary_rx_act(prim_act), .o_other_rx_act(other_act)
	);

	// free running clock, 8 ns period
	always #4 clk = ~clk;

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// strobe held for one edge, result read one edge later
	task automatic write_policy(input logic [1:0] v);
		@(posedge clk);
		policy_wr  <= 1'b1;
		policy_val <= v;
		@(posedge clk);
		policy_wr <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic write_delay(input logic [7:0] v);
		@(posedge clk);
		delay_wr  <= 1'b1;
		delay_val <= v;
		@(posedge clk);
		delay_wr <= 1'b0;
	endtask
	task automatic idle_check_awake(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// waits whole milliseconds of the shortened timebase, then settles
	task automatic wait_ms(input int n);
		repeat (n * MS_CYC) @(posedge clk);
		#1;
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// watchdog: the tests take about 511 us with the short timebase
	initial begin
		#700_000;
		bad_count++;
		$display("watchdog expired");
		summarize();
	end

	initial begin
		clk        = 1'b0;
		resetn     = 1'b0;
		ce         = 1'b1;
		state      = 3'h0;
		delay_wr   = 1'b0;
		delay_val  = 8'h00;
		policy_wr  = 1'b0;
		policy_val = 2'h0;
		bad_count  = 0;
		tests_run  = 0;
		@(posedge clk);
		#1;
		check(8'(asleep), 8'h00);
		check(8'(policy), 8'h00);
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		$display("test reset done");
		// every module state shows its pattern start level, also the voice override
		for (int s = 0; s < 8; s++) begin
			@(posedge clk);
			state <= 3'(s);
			repeat (3) @(posedge clk);
			#1;
			check(8'(led), start_lvl[s]);
		end
		$display("test patterns done");
		// blink timing, checked mid-phase so tick alignment cannot flip a result
		@(posedge clk);
		state <= status_sleep_pkg::ST_NO_SIM;
		wait_ms(300);
		check(8'(led), 8'h01);
		wait_ms(600);
		check(8'(led), 8'h00);
		wait_ms(600);
		check(8'(led), 8'h01);
		@(posedge clk);
		state <= status_sleep_pkg::ST_STANDBY;
		wait_ms(37);
		check(8'(led), 8'h00);
		wait_ms(963);
		check(8'(led), 8'h01);
		wait_ms(2112);
		check(8'(led), 8'h00);
		@(posedge clk);
		state <= status_sleep_pkg::ST_DATA_LINK;
		wait_ms(37);
		check(8'(led), 8'h00);
		wait_ms(75);
		check(8'(led), 8'h01);
		wait_ms(75);
		check(8'(led), 8'h00);
		@(posedge clk);
		state <= status_sleep_pkg::ST_VOICE;
		wait_ms(700);
		check(8'(led), 8'h00);
		// registering falls back to standby once the limit has passed
		@(posedge clk);
		state <= status_sleep_pkg::ST_REGISTERING;
		wait_ms(300);
		check(8'(led), 8'h01);
		wait_ms(15100);
		check(8'(led), 8'h01);
		wait_ms(900);
		check(8'(led), 8'h01);
		@(posedge clk);
		state <= status_sleep_pkg::ST_STANDBY;
		$display("test blink timing done");
		// every policy code, then a write with the clock enable low is ignored
		for (int v = 0; v < 4; v++) begin
			write_policy(2'(v));
			check(8'(policy), 8'(v));
		end
		ce <= 1'b0;
		write_policy(2'h2);
		check(8'(policy), 8'h03);
		ce <= 1'b1;
		$display("test policy done");
		// zero delay never sleeps; a written delay does; only the primary port wakes
		wait_ms(300);
		check(8'(asleep), 8'h00);
		write_delay(8'h02);
		wait_ms(1900);
		check(8'(asleep), 8'h00);
		wait_ms(200);
		check(8'(asleep), 8'h01);
		check(8'(led), 8'h01);
		host_ap_model_inst.send_cmds(1'b0, 4);
		#1;
		check(8'(asleep), 8'h01);
		host_ap_model_inst.send_cmds(1'b1, 1);
		#1;
		check(8'(asleep), 8'h00);
		// edge policy: either transition wakes, idle time returns it to sleep
		write_delay(8'h01);
		wait_ms(1100);
		check(8'(asleep), 8'h01);
		write_policy(2'h0);
		host_ap_model_inst.set_wake(1'b0);
		idle_check_awake(1);
		check(8'(asleep), 8'h00);
		wait_ms(1100);
		check(8'(asleep), 8'h01);
		host_ap_model_inst.set_wake(1'b1);
		idle_check_awake(1);
		check(8'(asleep), 8'h00);
		// level policies: the blocking level keeps it awake and also wakes it
		write_policy(2'h2);
		wait_ms(1100);
		check(8'(asleep), 8'h00);
		host_ap_model_inst.set_wake(1'b0);
		wait_ms(1100);
		check(8'(asleep), 8'h01);
		host_ap_model_inst.set_wake(1'b1);
		idle_check_awake(1);
		check(8'(asleep), 8'h00);
		write_policy(2'h1);
		host_ap_model_inst.set_wake(1'b0);
		wait_ms(1100);
		check(8'(asleep), 8'h00);
		host_ap_model_inst.set_wake(1'b1);
		wait_ms(1100);
		check(8'(asleep), 8'h01);
		host_ap_model_inst.set_wake(1'b0);
		idle_check_awake(1);
		check(8'(asleep), 8'h00);
		host_ap_model_inst.set_wake(1'b1);
		$display("test sleep gating done");
		// reset in mid-run drops the stored settings
		write_policy(2'h2);
		@(posedge clk);
		resetn <= 1'b0;
		#1;
		check(8'(policy), 8'h00);
		check(8'(led), 8'h00);
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		idle_check_awake(3);
		check(8'(asleep), 8'h00);
		// the delay written before the reset must be gone
		wait_ms(1100);
		check(8'(asleep), 8'h00);
		$display("test second reset done");
		summarize();
	end
endmodule
